// file: common/otgid_params.svh
// Constants of the OTG ID and VBUS detection unit.
// Assumes inclusion by bare name from design and bench files.
`ifndef OTGID_PARAMS_SVH
`define OTGID_PARAMS_SVH

// Bit positions in the interrupt status byte.
`define OTGID_ST_VBUS_VALID 1
`define OTGID_ST_SESS_VALID 2
`define OTGID_ST_SESS_END 3
`define OTGID_ST_ID_GND 4
// Bit position of the floating flag in the carkit status byte.
`define OTGID_CK_ID_FLOAT 0
// Bit positions in the OTG control byte.
`define OTGID_CTL_ID_PULL 0
`define OTGID_CTL_DISCHARGE 3
`define OTGID_CTL_CHARGE 4
// Resistor codes of the ID converter.
`define OTGID_RID_GND 3'h0
`define OTGID_RID_R75 3'h1
`define OTGID_RID_R102K 3'h2
`define OTGID_RID_R200K 3'h3
`define OTGID_RID_FLOAT 3'h5
`define OTGID_RID_NONE 3'h7
// Settle time after enabling the strong pull-up, in ms, and its cycle count at 40 MHz.
`define OTGID_SETTLE_MS 50
`define OTGID_CLK_KHZ 40000
`define OTGID_SETTLE_CYC (`OTGID_SETTLE_MS * `OTGID_CLK_KHZ)

`endif

// file: common/otgid_pkg.sv
// Types shared by both ends of the OTG ID and VBUS detection unit.
// Assumes nothing beyond a SystemVerilog compiler.
package otgid_pkg;

    typedef enum logic [3:0] {
        OTGID_L_IDLE = 4'b0001,
        OTGID_L_SETTLE = 4'b0010,
        OTGID_L_CHECK = 4'b0100,
        OTGID_L_MEAS = 4'b1000
    } otgid_link_state_t;

    // Edge enables: one bit per comparator except the float one.
    typedef struct packed {
        logic id_gnd;
        logic sess_end;
        logic sess_valid;
        logic vbus_valid;
    } otgid_edge_en_t;

endpackage

// file: common/otgid_if.sv
// Interface between the detection unit and the link controller.
// Assumes both ends run on the one system clock.
`timescale 1ns/10ps
`default_nettype none
interface otgid_if;
    import otgid_pkg::*;
    logic id_strong_pull_enable;
    logic float_rise_event_enable;
    logic float_fall_event_enable;
    logic vbus_discharge_enable;
    logic vbus_charge_enable;
    otgid_edge_en_t rise_en;
    otgid_edge_en_t fall_en;
    logic [7:0] irq_status;
    logic [7:0] carkit_status;
    logic [2:0] rid_code;
    logic event_pulse;
    logic event_alt;
    logic [7:0] otg_ctrl;

    modport dev (
        input id_strong_pull_enable, float_rise_event_enable, float_fall_event_enable,
        input vbus_discharge_enable, vbus_charge_enable, rise_en, fall_en,
        output irq_status, carkit_status, rid_code, event_pulse, event_alt, otg_ctrl
    );
    modport link (
        output id_strong_pull_enable, float_rise_event_enable, float_fall_event_enable,
        output vbus_discharge_enable, vbus_charge_enable, rise_en, fall_en,
        input irq_status, carkit_status, rid_code, event_pulse, event_alt, otg_ctrl
    );
endinterface
`default_nettype wire

// file: src/otgid_device.sv
// Device end: synchronises the ID and VBUS comparators, builds status and change events.
// Assumes comparator levels arrive asynchronously from the analog front end.
//
// Summary of operation
// (RULE_01) Link enables pull-up, waits, then samples.
// (RULE_02) Grounded flag: 0 for A, 1 for B.
// (RULE_03) Weak pull-up; resistor drops flag, raises event.
// (RULE_04) Resistor code reported only with pull-up off.
// (RULE_05) Link measures resistance after a ground change.
// (RULE_06) Pull-up on bit; float edges give alt events.
// (RULE_07) Ground/float flags: 11 float, 10 102K, 00 ground.
// (RULE_08) Ground flag status bit 4; float carkit bit 0.
// (RULE_09) Ground flag edge events per edge enables.
// (RULE_10) Cleared enables leave only weak pull-up.
// (RULE_11) Comparator levels readable in status byte.
// (RULE_12) Link uses each comparator per device role.
// (RULE_13) Session end flag rises when VBUS drops.
// (RULE_14) Session end reads 0 with both enables cleared.
// (RULE_15) Link disables session end unless OTG.
// (RULE_16) Discharge pull-down on control bit 3.
// (RULE_17) Charge pull-up on control bit 4.
// (RULE_18) Comparators pass a synchroniser before use.
`timescale 1ns/10ps
`default_nettype none
`include "otgid_params.svh"
module otgid_device (
    input wire logic sys_clk_i, // 40 MHz clock
    input wire logic resetn_i, // Asynchronous reset, active low
    otgid_if.dev lnk, // Link side
    input wire logic id_gnd_cmp_i, // Analog ID-grounded comparator
    input wire logic id_float_cmp_i, // Analog ID-floating comparator
    input wire logic [2:0] rid_meas_i, // Resistor converter result
    input wire logic vbus_valid_cmp_i, // VBUS valid comparator
    input wire logic sess_valid_cmp_i, // Session valid comparator
    input wire logic sess_end_cmp_i, // Session end comparator
    output logic strong_pull_o, // Connect 100K ID pull-up
    output logic weak_pull_o, // Connect weak ID pull-up
    output logic discharge_o, // VBUS pull-down switch
    output logic charge_o // VBUS pull-up switch
);
    import otgid_pkg::*;

    localparam int NCMP = 5;
    // Index of each comparator in the per-comparator vectors below.
    localparam int IX_VBUS = 0;
    localparam int IX_SVLD = 1;
    localparam int IX_SEND = 2;
    localparam int IX_ID_GROUNDED_FLAG = 3;
    localparam int IX_IDFLT = 4;

    // Three synchroniser stages per comparator, then the accepted level.
    typedef struct packed {
        logic [NCMP-1:0] s1;
        logic [NCMP-1:0] s2;
        logic [NCMP-1:0] s3;
        logic [NCMP-1:0] st; // Accepted comparator levels

        logic [2:0] m1;
        logic [2:0] m2;
        logic [2:0] m3;
        logic [2:0] rid_st; // Accepted converter word

        logic [7:0] irq_status;
        logic [7:0] carkit_status;
        logic [7:0] otg_ctrl;
        logic [2:0] rid_code;
        logic event_pulse;
        logic event_alt;

        logic strong_pull;
        logic weak_pull;
        logic discharge;
        logic charge;
    } otgid_dev_state_t;

    otgid_dev_state_t r;
    otgid_dev_state_t next_r;
    logic [NCMP-1:0] raw;
    logic [NCMP-1:0] agree;
    logic [NCMP-1:0] rise;
    logic [NCMP-1:0] fall;
    logic [NCMP-1:0] en_r;
    logic [NCMP-1:0] en_f;
    logic [NCMP-1:0] hit;
    logic sess_end_on;
    logic main_hit;
    logic alt_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator levels and their edge enables, highest index first.
    assign raw = {
        id_float_cmp_i,
        id_gnd_cmp_i,
        sess_end_cmp_i,
        sess_valid_cmp_i,
        vbus_valid_cmp_i
    };
    // The float comparator has its own enable pair, apart from the four edge enables.
    assign en_r = {
        lnk.float_rise_event_enable,
        lnk.rise_en.id_gnd,
        lnk.rise_en.sess_end,
        lnk.rise_en.sess_valid,
        lnk.rise_en.vbus_valid
    };
    assign en_f = {
        lnk.float_fall_event_enable,
        lnk.fall_en.id_gnd,
        lnk.fall_en.sess_end,
        lnk.fall_en.sess_valid,
        lnk.fall_en.vbus_valid
    };

    ////////////////////////////////////////////////////////////////////////////////
    // A level is taken once the second and third stages agree, so a metastable
    // first stage never reaches the status or event logic.
    // An edge only counts as an event while its own enable is set; the level still updates.
    genvar g;
    generate
        for (g = 0; g < NCMP; g++) begin : g_edge
            assign agree[g] = (r.s2[g] == r.s3[g]); // see (RULE_18)
            assign rise[g] = agree[g] && r.s3[g] && !r.st[g]; // see (RULE_18)
            assign fall[g] = agree[g] && !r.s3[g] && r.st[g]; // see (RULE_18)
            assign hit[g] = (rise[g] && en_r[g]) || (fall[g] && en_f[g]); // see (RULE_09)
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Session end counts as switched off when neither of its edges is enabled.
    assign sess_end_on = lnk.rise_en.sess_end | lnk.fall_en.sess_end; // see (RULE_14)
    // Its edges stay silent while it is off; float edges leave as alternate events.
    assign main_hit = hit[IX_VBUS] | hit[IX_SVLD] | (hit[IX_SEND] & sess_end_on)
                      | hit[IX_ID_GROUNDED_FLAG]; // see (RULE_03) see (RULE_09)
    assign alt_hit = hit[IX_IDFLT]; // see (RULE_06)

    ////////////////////////////////////////////////////////////////////////////////
    // One pass builds the whole next state; the register below is the only storage.
    always_comb begin
        next_r = r;
        next_r.s1 = raw;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.st = r.st ^ (rise | fall);

        // The converter word is taken whole once two stages agree on every bit, so a
        // word caught while it changes never reaches the link.
        next_r.m1 = rid_meas_i;
        next_r.m2 = r.m1;
        next_r.m3 = r.m2;
        if (r.m2 == r.m3) begin
            next_r.rid_st = r.m3;
        end

        // Status bits that this unit does not own read as zero.
        next_r.irq_status = 8'h00;
        next_r.irq_status[`OTGID_ST_VBUS_VALID] = r.st[IX_VBUS]; // see (RULE_11)
        next_r.irq_status[`OTGID_ST_SESS_VALID] = r.st[IX_SVLD]; // see (RULE_11)
        next_r.irq_status[`OTGID_ST_SESS_END] = r.st[IX_SEND] & sess_end_on; // see (RULE_13) see (RULE_14)
        next_r.irq_status[`OTGID_ST_ID_GND] = r.st[IX_ID_GROUNDED_FLAG]; // see (RULE_02) see (RULE_07) see (RULE_08)
        next_r.carkit_status = 8'h00;
        next_r.carkit_status[`OTGID_CK_ID_FLOAT] = r.st[IX_IDFLT]; // see (RULE_07) see (RULE_08)

        // The control byte echoes the link's pull-up, discharge and charge enables, one cycle late.
        next_r.otg_ctrl = 8'h00;
        next_r.otg_ctrl[`OTGID_CTL_ID_PULL] = lnk.id_strong_pull_enable; // see (RULE_06)
        next_r.otg_ctrl[`OTGID_CTL_DISCHARGE] = lnk.vbus_discharge_enable; // see (RULE_16)
        next_r.otg_ctrl[`OTGID_CTL_CHARGE] = lnk.vbus_charge_enable; // see (RULE_17)
        next_r.strong_pull = lnk.id_strong_pull_enable; // see (RULE_06) see (RULE_10)
        // The weak pull-up stays on, so a floating pin reads high with the strong one off.
        next_r.weak_pull = 1'b1; // see (RULE_03) see (RULE_10)
        next_r.discharge = lnk.vbus_discharge_enable; // see (RULE_16)
        next_r.charge = lnk.vbus_charge_enable; // see (RULE_17)

        // The converter only reads true with the strong pull-up out of the way.
        if (lnk.id_strong_pull_enable) begin
            next_r.rid_code = `OTGID_RID_NONE; // see (RULE_04)
        end else begin
            next_r.rid_code = r.rid_st; // see (RULE_04)
        end
        next_r.event_alt = alt_hit; // see (RULE_06)
        next_r.event_pulse = main_hit | alt_hit; // see (RULE_03) see (RULE_09)
    end

    // The weak pull-up is already on in reset, so the pin is never left undefined.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '{weak_pull: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // After reset every accepted level is low, so a comparator that is already true
    // gives one rising edge once the synchroniser has filled, and an event if its rise enable is set;
    // the link should let the first few cycles after reset pass before it trusts an event.
    assign lnk.irq_status = r.irq_status;
    assign lnk.carkit_status = r.carkit_status;
    assign lnk.otg_ctrl = r.otg_ctrl;
    assign lnk.rid_code = r.rid_code;
    assign lnk.event_pulse = r.event_pulse;
    assign lnk.event_alt = r.event_alt;

    // Pin controls.
    assign strong_pull_o = r.strong_pull;
    assign weak_pull_o = r.weak_pull; // see (RULE_03) see (RULE_10)
    assign discharge_o = r.discharge;
    assign charge_o = r.charge;
endmodule
`default_nettype wire

// file: src/otgid_link.sv
// Link end: drives enables, runs the cable check sequence, reports results.
// Assumes the device end answers on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "otgid_params.svh"
module otgid_link #(
    parameter int SETTLE_CYC = `OTGID_SETTLE_CYC // Pull-up settle time in cycles
) (
    input wire logic sys_clk_i, // 40 MHz clock
    input wire logic resetn_i, // Asynchronous reset, active low
    otgid_if.link dev, // Device side
    input wire logic check_i, // Start a cable check, pulse
    input wire logic otg_mode_i, // Dual-role use; else session end is disabled
    input wire logic save_power_i, // Drop pull-up and float enables
    input wire logic discharge_i, // Request VBUS discharge
    input wire logic charge_i, // Request VBUS charge
    input wire logic [3:0] host_rise_en_i, // Rising enables, vbus/sess/end/id
    input wire logic [3:0] host_fall_en_i, // Falling enables
    output logic busy_o, // Check in progress
    output logic done_o, // Check finished, pulse
    output logic a_plug_o, // Last check saw a grounded ID
    output logic [2:0] rid_o // Last measured resistor code
);
    import otgid_pkg::*;

    typedef struct packed {
        otgid_link_state_t st;
        logic [31:0] cnt;
        logic pull;
        logic busy;
        logic done;
        logic a_plug;
        logic [2:0] rid;
    } otgid_link_reg_t;

    otgid_link_reg_t r;
    otgid_link_reg_t next_r;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        case (r.st)
            OTGID_L_IDLE: begin
                next_r.busy = 1'b0;
                if (check_i) begin
                    next_r.pull = 1'b1; // see (RULE_01)
                    next_r.cnt = 32'h0;
                    next_r.busy = 1'b1;
                    next_r.st = OTGID_L_SETTLE;
                end
            end
            OTGID_L_SETTLE: begin
                next_r.cnt = r.cnt + 32'h1;
                if (r.cnt >= 32'(SETTLE_CYC - 1)) begin
                    next_r.st = OTGID_L_CHECK; // see (RULE_01)
                end
            end
            OTGID_L_CHECK: begin
                next_r.a_plug = !dev.irq_status[`OTGID_ST_ID_GND]; // see (RULE_01)
                // Pull-up must be off for the converter to read.
                next_r.pull = 1'b0; // see (RULE_04) see (RULE_05)
                next_r.cnt = 32'h0;
                next_r.st = OTGID_L_MEAS;
            end
            OTGID_L_MEAS: begin
                next_r.cnt = r.cnt + 32'h1;
                if (r.cnt >= 32'h3) begin
                    next_r.rid = dev.rid_code; // see (RULE_05)
                    next_r.done = 1'b1;
                    next_r.busy = 1'b0;
                    next_r.st = OTGID_L_IDLE;
                end
            end
            default: begin
                next_r.st = OTGID_L_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '{st: OTGID_L_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign dev.id_strong_pull_enable = r.pull & !save_power_i; // see (RULE_10)
    assign dev.float_rise_event_enable = r.pull & !save_power_i; // see (RULE_10)
    assign dev.float_fall_event_enable = r.pull & !save_power_i; // see (RULE_10)
    assign dev.vbus_discharge_enable = discharge_i;
    assign dev.vbus_charge_enable = charge_i;
    // Session end is only meaningful to a dual-role B-device.
    assign dev.rise_en = {host_rise_en_i[3], host_rise_en_i[2] & otg_mode_i,
                          host_rise_en_i[1:0]}; // see (RULE_12) see (RULE_15)
    assign dev.fall_en = {host_fall_en_i[3], host_fall_en_i[2] & otg_mode_i,
                          host_fall_en_i[1:0]}; // see (RULE_12) see (RULE_15)
    assign busy_o = r.busy;
    assign done_o = r.done;
    assign a_plug_o = r.a_plug;
    assign rid_o = r.rid;
endmodule
`default_nettype wire

// file: dv/otgid_sva.sv
// Checker of the interface between the detection unit and the link end.
// Assumes the bench instantiates it beside that interface on the same clock and reset.
`timescale 1ns/10ps
`default_nettype none
`include "otgid_params.svh"
module otgid_sva (
    input wire logic sys_clk_i, // Clock
    input wire logic resetn_i, // Reset, active low
    input wire logic id_strong_pull_enable, // Pull-up request
    input wire logic float_rise_event_enable, // Float rise enable
    input wire logic vbus_discharge_enable, // Discharge request
    input wire otgid_pkg::otgid_edge_en_t rise_en, // Rising enables
    input wire otgid_pkg::otgid_edge_en_t fall_en, // Falling enables
    input wire logic [7:0] irq_status, // Status byte
    input wire logic [7:0] carkit_status, // Carkit status
    input wire logic [2:0] rid_code, // Resistor code
    input wire logic event_pulse, // Change event
    input wire logic event_alt, // Alternate event
    input wire logic [7:0] otg_ctrl // Control byte
);
    import otgid_pkg::*;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////////////
    sequence s_se_off;
        (!rise_en.sess_end && !fall_en.sess_end) [*3];
    endsequence
    sequence s_id_rise;
        rise_en.id_gnd [*2] ##0 $rose(irq_status[`OTGID_ST_ID_GND]);
    endsequence
    sequence s_float_rise;
        float_rise_event_enable [*2] ##0 $rose(carkit_status[`OTGID_CK_ID_FLOAT]);
    endsequence
    property p_se_off;
        s_se_off |-> !irq_status[`OTGID_ST_SESS_END];
    endproperty
    property p_se_rise;
        $rose(irq_status[`OTGID_ST_SESS_END]) |-> $past(rise_en.sess_end || fall_en.sess_end);
    endproperty
    property p_pull;
        $rose(id_strong_pull_enable) |=> otg_ctrl[`OTGID_CTL_ID_PULL];
    endproperty
    property p_disch;
        $changed(vbus_discharge_enable) |=> otg_ctrl[`OTGID_CTL_DISCHARGE] == $past(vbus_discharge_enable);
    endproperty
    property p_rid_none;
        id_strong_pull_enable [*2] |-> rid_code == `OTGID_RID_NONE;
    endproperty
    property p_id_evt;
        s_id_rise |-> $past(event_pulse);
    endproperty
    property p_alt_pulse;
        event_alt |-> event_pulse;
    endproperty
    property p_alt_float;
        s_float_rise |-> $past(event_alt);
    endproperty
    ////////////////////////////////////////////////////////////////////////
    a_se_off: assert property (p_se_off) else $error("session end high while disabled");
    a_se_rise: assert property (p_se_rise) else $error("session end rose while disabled");
    a_pull: assert property (p_pull) else $error("pull-up bit not set");
    a_disch: assert property (p_disch) else $error("discharge bit wrong");
    a_rid_none: assert property (p_rid_none) else $error("resistor code valid with pull-up on");
    a_id_evt: assert property (p_id_evt) else $error("no event on ground flag rise");
    a_alt_pulse: assert property (p_alt_pulse) else $error("alternate event alone");
    a_alt_float: assert property (p_alt_float) else $error("no alternate event on float rise");
endmodule
`default_nettype wire

// file: dv/tb.sv
// Bench joining the device and link ends through the interface.
// Assumes a short settle count, so a cable check lasts a few dozen cycles.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import otgid_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic gnd_c = 1'b1, flt_c = 1'b1, vb_c = 1'b0, sv_c = 1'b0, se_c = 1'b0;
    logic [2:0] rid_m = 3'h5;
    logic go = 1'b0, otg = 1'b1, save = 1'b0, dis = 1'b0, chg = 1'b0;
    logic [3:0] ren = 4'hf, fen = 4'hf;
    logic spull, wpull, dis_o, chg_o, busy, done, a_plug;
    logic [2:0] rid;
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    int n_mismatch = 0, checks = 0;
    logic [3:0] exp_q[$];
    always #12.5 sys_clk = ~sys_clk;
    otgid_if i_otgid_if();
    otgid_device i_otgid_device (.sys_clk_i(sys_clk), .resetn_i(resetn), .lnk(i_otgid_if), .id_gnd_cmp_i(gnd_c),
        .id_float_cmp_i(flt_c), .rid_meas_i(rid_m), .vbus_valid_cmp_i(vb_c), .sess_valid_cmp_i(sv_c),
        .sess_end_cmp_i(se_c), .strong_pull_o(spull), .weak_pull_o(wpull), .discharge_o(dis_o), .charge_o(chg_o));
    otgid_link #(.SETTLE_CYC(20)) i_otgid_link (.sys_clk_i(sys_clk), .resetn_i(resetn), .dev(i_otgid_if),
        .check_i(go), .otg_mode_i(otg), .save_power_i(save), .discharge_i(dis), .charge_i(chg),
        .host_rise_en_i(ren), .host_fall_en_i(fen), .busy_o(busy), .done_o(done), .a_plug_o(a_plug), .rid_o(rid));
    otgid_sva i_otgid_sva (.sys_clk_i(sys_clk), .resetn_i(resetn),
        .id_strong_pull_enable(i_otgid_if.id_strong_pull_enable), .rid_code(i_otgid_if.rid_code),
        .float_rise_event_enable(i_otgid_if.float_rise_event_enable), .otg_ctrl(i_otgid_if.otg_ctrl),
        .vbus_discharge_enable(i_otgid_if.vbus_discharge_enable), .rise_en(i_otgid_if.rise_en),
        .fall_en(i_otgid_if.fall_en), .irq_status(i_otgid_if.irq_status), .event_alt(i_otgid_if.event_alt),
        .carkit_status(i_otgid_if.carkit_status), .event_pulse(i_otgid_if.event_pulse));
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic evt(input logic want);
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            @(negedge sys_clk);
            seen |= i_otgid_if.event_pulse;
        end
        cmp("event_pulse", {7'h0, want}, {7'h0, seen});
    endtask
    // A second start while busy must be ignored, so exactly one result is queued.
    task automatic cable(input logic a_e, input logic [2:0] code);
        {gnd_c, flt_c} = {~a_e, 1'b0};
        rid_m = code;
        cyc(6);
        exp_q.push_back({a_e, code});
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        flt_c = ~a_e;
        cyc(3);
        cmp("strong_pull_o", 8'h1, {7'h0, spull});
        cmp("rid_code", 8'h7, {5'h0, i_otgid_if.rid_code});
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cmp("event_alt", {7'h0, ~a_e}, {7'h0, i_otgid_if.event_alt});
        for (int i = 0; i < 100 && busy !== 1'b0; i++) cyc(1);
        cyc(2);
        cmp("busy_pull", 8'h0, {6'h0, busy, spull});
        cmp("pending", 8'h0, 8'(exp_q.size()));
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(negedge sys_clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) cmp("done_o", 8'h0, 8'h1);
            else cmp("plug_rid", {4'h0, exp_q.pop_front()}, {4'h0, a_plug, rid});
        end
    end
    initial begin
        #100us;
        n_mismatch++;
        $display("Error watchdog expected done seen timeout");
        tally_and_finish;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(20));
        cyc(10);
        resetn = 1'b1;
        cyc(8);
        for (int i = 0; i < 6; i++) begin
            {gnd_c, flt_c} = (i % 3 == 0) ? 2'b11 : (i % 3 == 1) ? 2'b10 : 2'b00;
            {vb_c, sv_c, se_c} = 3'($urandom);
            cyc(6);
            cmp("irq_status", {3'h0, gnd_c, se_c, sv_c, vb_c, 1'b0}, i_otgid_if.irq_status & 8'h1e);
            cmp("carkit", {7'h0, flt_c}, i_otgid_if.carkit_status & 8'h01);
        end
        vb_c = ~vb_c;
        cyc(4);
        cmp("vbus_early", {7'h0, ~vb_c}, {7'h0, i_otgid_if.irq_status[1]});
        cyc(1);
        cmp("vbus_late", {7'h0, vb_c}, {7'h0, i_otgid_if.irq_status[1]});
        se_c = 1'b0;
        cyc(6);
        se_c = 1'b1;
        evt(1'b1);
        cmp("sess_end", 8'h1, {7'h0, i_otgid_if.irq_status[3]});
        otg = 1'b0;
        cyc(4);
        cmp("sess_end_off", 8'h0, {7'h0, i_otgid_if.irq_status[3]});
        otg = 1'b1;
        {gnd_c, flt_c} = 2'b10;
        ren = 4'h7;
        fen = 4'h7;
        cyc(8);
        gnd_c = 1'b0;
        evt(1'b0);
        ren = 4'hf;
        gnd_c = 1'b1;
        evt(1'b1);
        fen = 4'hf;
        for (int i = 0; i < 4; i++) begin
            {chg, dis} = 2'(i);
            cyc(3);
            cmp("otg_ctrl", {3'h0, chg, dis, 3'h0}, i_otgid_if.otg_ctrl & 8'h18);
            cmp("vbus_switch", {6'h0, chg, dis}, {6'h0, chg_o, dis_o});
        end
        // A check started in power-save mode keeps the strong pull-up off until save drops.
        exp_q.push_back({1'b0, 3'h5});
        save = 1'b1;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(3);
        cmp("save_pulls", 8'h02, {5'h0, i_otgid_if.float_rise_event_enable, wpull, spull});
        save = 1'b0;
        cyc(3);
        cmp("pull_back", 8'h1, {7'h0, spull});
        for (int i = 0; i < 100 && busy !== 1'b0; i++) cyc(1);
        cyc(2);
        for (int i = 0; i < 4; i++) cable(i[0], codes[$urandom % 5]);
        tally_and_finish;
    end
endmodule
`default_nettype wire
